// ### design/dswp_pkg.sv
// Notes on behaviour
// - Frame sync low enables the shift register.
// - Data sampled on each serial clock falling edge.
// - Each frame holds exactly twenty-four bits.
// - Twenty-fourth falling edge transfers word, updates output.
// - Early frame sync rise aborts, output unchanged.
// - Bits 19..2 hold code; 19..4 coarse, 3..2 fine.
// - Code is straight binary over bits two to nineteen.
package dswp_pkg;

   // ----------------------------------------------------------------
   // Frame layout
   // ----------------------------------------------------------------
   localparam int          FRAME_BITS  = 24;
   localparam int          CNT_W       = 5;
   localparam logic [4:0]  LAST_BIT    = 5'h17;
   localparam int          CODE_MSB    = 19;
   localparam int          CODE_LSB    = 2;
   localparam int          CODE_W      = 18;
   localparam int          COARSE_LSB  = 4;
   localparam int          COARSE_W    = 16;
   localparam int          FINE_W      = 2;
   localparam int          FULL_SCALE  = 262144;
   localparam logic [17:0] CODE_RESET  = 18'h0_0000;
   localparam logic [23:0] WORD_RESET  = 24'h00_0000;
   localparam int          BUF_DEPTH   = 2;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [15:0] coarse;
      logic [1:0]  fine;
   } dswp_code_t;

   typedef struct packed {
      logic [23:0] word;
      dswp_code_t  code;
   } dswp_frame_t;

endpackage : dswp_pkg

// ### design/dswp_shifter.sv
`timescale 1ns/1ps
// Link-side shifter on the serial clock; posts each complete word by toggle.
module dswp_shifter (
   input  wire logic                sclk,
   input  wire logic                syncN,
   input  wire logic                din,
   output logic [23:0]              wordOut,
   output logic                     wordTgl
);

   logic [4:0]  bitCnt;
   logic [22:0] shiftReg;
   // The link side has no reset, so the posted word and its toggle start from a known value.
   logic [23:0] wordHold_reg = 24'h00_0000;
   logic        wordTgl_reg  = 1'b0;

   // Falling edges shift; a high frame sync resets the count so a short frame is lost.
   always_ff @(negedge sclk or posedge syncN) begin
      if (syncN) begin
         bitCnt   <= 5'h00;
         shiftReg <= 23'h00_0000;
      end else begin
         shiftReg <= {shiftReg[21:0], din};
         if (bitCnt == dswp_pkg::LAST_BIT) begin
            bitCnt <= 5'h00;
         end else begin
            bitCnt <= bitCnt + 5'h01;
         end
      end
   end

   // Word and toggle are only touched on the final edge, so an abort never disturbs them.
   always_ff @(negedge sclk) begin
      if (!syncN && bitCnt == dswp_pkg::LAST_BIT) begin
         wordHold_reg <= {shiftReg, din};
         wordTgl_reg  <= ~wordTgl_reg;
      end
   end

   assign wordOut = wordHold_reg;
   assign wordTgl = wordTgl_reg;

endmodule : dswp_shifter

// ### design/dswp_buffer.sv
`timescale 1ns/1ps
module dswp_buffer (
   input  wire logic                  core_clk,
   input  wire logic                  resetn,
   input  wire logic                  clkEn,
   input  wire logic                  inValid,
   output logic                       inReady,
   input  wire dswp_pkg::dswp_frame_t inData,
   output logic                       outValid,
   input  wire logic                  outReady,
   output dswp_pkg::dswp_frame_t      outData
);

   dswp_pkg::dswp_frame_t mem [dswp_pkg::BUF_DEPTH];
   logic                  wrPtr;
   logic                  rdPtr;
   logic [1:0]            count;
   logic                  doWr;
   logic                  doRd;

   assign inReady  = (count != 2'h2);
   assign outValid = (count != 2'h0);
   assign outData  = mem[rdPtr];
   assign doWr     = clkEn && inValid && inReady;
   assign doRd     = clkEn && outValid && outReady;

   always_ff @(posedge core_clk) begin
      if (doWr) begin
         mem[wrPtr] <= inData;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         wrPtr <= 1'b0;
         rdPtr <= 1'b0;
         count <= 2'h0;
      end else begin
         if (doWr) begin
            wrPtr <= ~wrPtr;
         end
         if (doRd) begin
            rdPtr <= ~rdPtr;
         end
         count <= count + {1'b0, doWr} - {1'b0, doRd};
      end
   end

endmodule : dswp_buffer

// ### design/dac_serial_write_port.sv
`timescale 1ns/1ps
module dac_serial_write_port (
   input  wire logic                core_clk,
   input  wire logic                resetn,
   input  wire logic                clkEn,
   input  wire logic                sclk,
   input  wire logic                syncN,
   input  wire logic                din,
   output logic                     codeValid,
   input  wire logic                codeReady,
   output logic [23:0]              wordRaw,
   output logic [17:0]              dacCode,
   output logic [15:0]              dacCoarse,
   output logic [1:0]               dacFine,
   output logic                     dropFlag
);

   // ----------------------------------------------------------------
   // Link domain
   // ----------------------------------------------------------------
   logic [23:0] linkWord;
   logic        linkTgl;

   dswp_shifter u_shifter (
      .sclk    (sclk),
      .syncN   (syncN),
      .din     (din),
      .wordOut (linkWord),
      .wordTgl (linkTgl)
   );

   // ----------------------------------------------------------------
   // Crossing: toggle synchroniser, word stable while toggle settles
   // ----------------------------------------------------------------
   logic tglMeta_reg;
   logic tglSync_reg;
   logic       tglSeen_reg;
   logic [2:0] warmUp_reg;
   logic       newWord;

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         tglMeta_reg <= 1'b0;
         tglSync_reg <= 1'b0;
         tglSeen_reg <= 1'b0;
      end else if (clkEn) begin
         tglMeta_reg <= linkTgl;
         tglSync_reg <= tglMeta_reg;
         tglSeen_reg <= tglSync_reg;
      end
   end

   // Word detection waits until the seen copy has caught up with the synchronised toggle.
   // The link toggle keeps its level through a core reset, so this avoids a false word.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         warmUp_reg <= 3'h0;
      end else if (clkEn) begin
         warmUp_reg <= {warmUp_reg[1:0], 1'b1};
      end
   end

   assign newWord = warmUp_reg[2] && (tglSync_reg ^ tglSeen_reg);

   // ----------------------------------------------------------------
   // Decode and buffer
   // ----------------------------------------------------------------
   dswp_pkg::dswp_frame_t inFrame;
   dswp_pkg::dswp_frame_t outFrame;
   logic                  bufInReady;
   logic                  bufOutValid;
   logic                  bufTake;

   always_comb begin
      inFrame.word        = linkWord;
      inFrame.code.coarse = linkWord[dswp_pkg::CODE_MSB:dswp_pkg::COARSE_LSB];
      inFrame.code.fine   = linkWord[dswp_pkg::COARSE_LSB-1:dswp_pkg::CODE_LSB];
   end

   dswp_buffer u_buffer (
      .core_clk (core_clk),
      .resetn   (resetn),
      .clkEn    (clkEn),
      .inValid  (newWord),
      .inReady  (bufInReady),
      .inData   (inFrame),
      .outValid (bufOutValid),
      .outReady (bufTake),
      .outData  (outFrame)
   );

   // Output register takes a word when empty or when the receiver accepts.
   assign bufTake = !codeValid || codeReady;

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         codeValid <= 1'b0;
         wordRaw   <= dswp_pkg::WORD_RESET;
         dacCode   <= dswp_pkg::CODE_RESET;
         dacCoarse <= 16'h0000;
         dacFine   <= 2'h0;
      end else if (clkEn) begin
         if (bufTake) begin
            codeValid <= bufOutValid;
            if (bufOutValid) begin
               wordRaw   <= outFrame.word;
               dacCode   <= outFrame.code;
               dacCoarse <= outFrame.code.coarse;
               dacFine   <= outFrame.code.fine;
            end
         end
      end
   end

   // Sticky flag when a word arrives with the buffer full.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         dropFlag <= 1'b0;
      end else if (clkEn && newWord && !bufInReady) begin
         dropFlag <= 1'b1;
      end
   end

endmodule : dac_serial_write_port

// ### bench/dswp_assertions.sv
`timescale 1ns/1ps
module dswp_assertions (
   input wire logic        core_clk,
   input wire logic        resetn,
   input wire logic        clkEn,
   input wire logic        sclk,
   input wire logic        syncN,
   input wire logic        din,
   input wire logic        codeValid,
   input wire logic        codeReady,
   input wire logic [23:0] wordRaw,
   input wire logic [17:0] dacCode,
   input wire logic [15:0] dacCoarse,
   input wire logic [1:0]  dacFine,
   input wire logic        dropFlag
);
   logic [4:0] fallCnt;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);
   // Counts link clock falls within a frame as seen from the core clock.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) fallCnt <= 5'h00;
      else if (syncN) fallCnt <= 5'h00;
      else if ($fell(sclk)) fallCnt <= (fallCnt == 5'h18) ? 5'h01 : fallCnt + 5'h01;
   end
   sequence sStall; codeValid && !(codeReady && clkEn); endsequence
   sequence sHeld; codeValid && $stable(wordRaw); endsequence
   a_stall_hold: assert property (sStall |=> sHeld)
      else $error("word lost in stall");
   a_code_field: assert property (codeValid |-> dacCode == wordRaw[19:2])
      else $error("bad code");
   a_coarse_field: assert property (codeValid |-> dacCoarse == wordRaw[19:4])
      else $error("bad coarse");
   a_fine_field: assert property (codeValid |-> dacFine == wordRaw[3:2])
      else $error("bad fine");
   a_code_binary: assert property (codeValid |-> dacCode == {dacCoarse, dacFine})
      else $error("code not binary");
   a_word_latency: assert property ($fell(sclk) && !syncN && fallCnt == 5'h17
      && !codeValid |-> ##[1:10] codeValid) else $error("word late");
   a_abort_quiet: assert property ($rose(syncN) && fallCnt != 5'h00
      && fallCnt != 5'h18 && !codeValid |=> !codeValid [*8]) else $error("abort gave word");
   a_drop_sticky: assert property (dropFlag |=> dropFlag)
      else $error("drop flag cleared");
endmodule : dswp_assertions

// ### bench/dswp_host.sv
`timescale 1ns/1ps
module dswp_host (
   output logic sclk,
   output logic syncN,
   output logic din
);
   initial begin
      sclk = 1'b1;
      syncN = 1'b1;
      din = 1'b0;
   end
   // Sends the top n bits; fewer than 24 aborts the frame.
   task automatic send(input logic [23:0] w, input int n);
      // The offset keeps the link edges away from the core clock edges when the task starts on a core clock edge.
      #7;
      syncN = 1'b0;
      for (int i = 23; i > 23 - n; i--) begin
         din = w[i];
         #32 sclk = 1'b0;
         #32 sclk = 1'b1;
      end
      syncN = 1'b1;
      din = ~din;
      #200;
   endtask : send
   // Toggles the link clock with frame sync high; the device must ignore these edges.
   task automatic idle_clocks(input int n);
      for (int i = 0; i < n; i++) begin
         #32 sclk = 1'b0;
         #32 sclk = 1'b1;
      end
   endtask : idle_clocks
endmodule : dswp_host

// ### bench/dac_serial_write_port_tb.sv
`timescale 1ns/1ps
module dac_serial_write_port_tb;
   logic        core_clk = 1'b0;
   logic        resetn = 1'b0;
   logic        clkEn = 1'b1;
   logic        codeReady = 1'b0;
   logic        sclk, syncN, din, codeValid, dropFlag;
   logic [23:0] wordRaw;
   logic [17:0] dacCode;
   logic [15:0] dacCoarse;
   logic [1:0]  dacFine;
   int          nErrors = 0;
   int          checkCount = 0;
   int          cyc = 0;
   logic [41:0] rows [4] = '{{24'h0F_FFFC, 18'h3_FFFF}, {24'hAB_CDEF, 18'h2_F37B},
                             {24'h00_0004, 18'h0_0001}, {24'hF0_0003, 18'h0_0000}};
   always #10 core_clk = ~core_clk;
   dswp_host u_host (.sclk(sclk), .syncN(syncN), .din(din));
   dac_serial_write_port u_dut (.core_clk(core_clk), .resetn(resetn), .clkEn(clkEn),
      .sclk(sclk), .syncN(syncN), .din(din), .codeValid(codeValid), .codeReady(codeReady),
      .wordRaw(wordRaw), .dacCode(dacCode), .dacCoarse(dacCoarse), .dacFine(dacFine),
      .dropFlag(dropFlag));
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      checkCount++;
      if (got !== exp) begin
         nErrors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic report_and_stop;
      $display("checks %0d errors %0d", checkCount, nErrors);
      if (nErrors == 0 && checkCount > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : report_and_stop
   task automatic take(input logic [41:0] r);
      for (int k = 0; k < 60; k++) begin
         @(negedge core_clk);
         if (codeValid === 1'b1) break;
      end
      chk(codeValid, 24'h00_0001);
      chk(wordRaw, r[41:18]);
      chk(dacCode, r[17:0]);
      chk(dacCoarse, r[17:2]);
      chk(dacFine, r[1:0]);
      @(posedge core_clk);
      codeReady <= 1'b1;
      @(posedge core_clk);
      codeReady <= 1'b0;
      @(posedge core_clk);
   endtask : take
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 5000) begin
         nErrors++;
         report_and_stop;
      end
   end
   initial begin
      repeat (2) @(posedge core_clk);
      resetn <= 1'b1;
      repeat (4) @(posedge core_clk);
      foreach (rows[i]) begin
         u_host.send(rows[i][41:18], 24);
         take(rows[i]);
      end
      // Four words against a stalled receiver: three are held, the fourth is dropped.
      u_host.send(rows[1][41:18], 24);
      u_host.send(rows[2][41:18], 24);
      @(negedge core_clk);
      chk(dropFlag, 24'h00_0000);
      // A low clock enable freezes the held word even with the receiver ready.
      @(posedge core_clk);
      clkEn     <= 1'b0;
      codeReady <= 1'b1;
      repeat (4) @(posedge core_clk);
      @(negedge core_clk);
      chk(codeValid, 24'h00_0001);
      chk(wordRaw, rows[1][41:18]);
      @(posedge core_clk);
      clkEn     <= 1'b1;
      codeReady <= 1'b0;
      u_host.send(rows[3][41:18], 24);
      @(negedge core_clk);
      chk(dropFlag, 24'h00_0000);
      u_host.send(rows[0][41:18], 24);
      @(negedge core_clk);
      chk(dropFlag, 24'h00_0001);
      take(rows[1]);
      take(rows[2]);
      take(rows[3]);
      u_host.idle_clocks(30);
      u_host.send(24'hFF_FFFF, 10);
      repeat (20) @(posedge core_clk);
      @(negedge core_clk);
      chk(codeValid, 24'h00_0000);
      u_host.send(rows[3][41:18], 24);
      take(rows[3]);
      resetn <= 1'b0;
      @(posedge core_clk);
      chk(wordRaw, 24'h00_0000);
      chk(dropFlag, 24'h00_0000);
      @(posedge core_clk);
      resetn <= 1'b1;
      // An odd word count leaves the link toggle high; the release must not invent a word.
      repeat (10) begin
         @(negedge core_clk);
         chk(codeValid, 24'h00_0000);
      end
      u_host.send(rows[2][41:18], 24);
      take(rows[2]);
      report_and_stop;
   end
endmodule : dac_serial_write_port_tb
bind dac_serial_write_port dswp_assertions u_chk (.core_clk(core_clk), .resetn(resetn),
   .clkEn(clkEn), .sclk(sclk), .syncN(syncN), .din(din), .codeValid(codeValid),
   .codeReady(codeReady), .wordRaw(wordRaw), .dacCode(dacCode), .dacCoarse(dacCoarse),
   .dacFine(dacFine), .dropFlag(dropFlag));
